// >>> hw/divider_stage.sv
// one programmable divider stage: a pulse out for every ratio pulses in
`timescale 1ns/1ns
`default_nettype none
module divider_stage
	import pll_divider_pkg::*;
#(
	parameter int W = DIV_W
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// divider path
	input  wire logic         tick,
	input  wire logic [W-1:0] ratio,
	output logic              pulse
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (W < 2)
	begin : g_bad_width
		$error("divider_stage needs W of at least 2");
	end

	typedef struct packed {
		logic [W-1:0] count;
		logic         pulse;
	} stage_t;

	stage_t st;
	stage_t next_st;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// compare with >= so a ratio lowered mid-count does not run away
	always_comb
	begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (tick)
		begin
			if (st.count + W'(1) >= ratio)
			begin
				next_st.count = '0;
				next_st.pulse = 1'b1;
			end
			else
				next_st.count = st.count + W'(1);
		end
		if (!reset_n)
			next_st = '0;
	end

	always_ff @(posedge clk)
		st <= next_st;

	assign pulse = st.pulse;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_pulse_follows_tick;
		@(posedge clk) disable iff (!reset_n)
		pulse |-> $past(tick);
	endproperty
	a_pulse_follows_tick: assert property (p_pulse_follows_tick)
		else $error("divider pulse without an input tick");

endmodule
`default_nettype wire

// >>> hw/pll_divider_config.sv
// divider chain configuration registers and the dividers they steer
//
// What this block does
// [R1] software writes output low divider odd or zero
// [R2] output low byte divides, resets to 0x31
// [R3] feedback high-speed ratio is code plus four
// [R4] feedback low-speed ratio is field plus one
// [R5] software keeps feedback low ratios even, 2..2^20
// [R6] feedback registers reset to 0xC0, 0x00, 0xF9
// [R7] clock input predivider, 19 bits, top 2:0
// [R8] free-run reference predivider, 19 bits, top 2:0
// [R9] output high-speed ratio is code plus four
// [R10] software writes reserved as reset, all bytes
`timescale 1ns/1ns
`default_nettype none
module pll_divider_config
	import pll_divider_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// register port from the serial control port
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output logic      [7:0]    reg_rdata,
	// upper output low-speed bits held elsewhere
	input  wire logic [11:0]   output_lowspeed_upper,
	input  wire logic          freerun_mode,
	// clock pins, sampled
	input  wire logic          vco_pin,
	input  wire logic          clock_input,
	input  wire logic          crystal_reference_pins,
	// ratios in force
	output logic      [3:0]    output_highspeed_divider,
	output logic      [20:0]   output_lowspeed_divider,
	output logic      [3:0]    feedback_highspeed_divider,
	output logic      [20:0]   feedback_lowspeed_divider,
	output logic      [19:0]   clock_input_predivider,
	output logic      [19:0]   freerun_reference_predivider,
	// divided pulses
	output logic               clock_output,
	output logic               feedback_pd_tick,
	output logic               reference_pd_tick
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  out_hs_ctrl;
		logic [7:0]  out_ls_low;
		logic [7:0]  fb_high_ctrl;
		logic [7:0]  fb_mid;
		logic [7:0]  fb_low;
		logic [7:0]  in_top;
		logic [7:0]  in_mid;
		logic [7:0]  in_low;
		logic [7:0]  fr_top;
		logic [7:0]  fr_mid;
		logic [7:0]  fr_low;
		logic [7:0]  rdata;
		logic [3:0]  out_hs_ratio;
		logic [20:0] out_ls_ratio;
		logic [3:0]  fb_hs_ratio;
		logic [20:0] fb_ls_ratio;
		logic [19:0] in_ratio;
		logic [19:0] fr_ratio;
		logic [2:0]  vco_sync;
		logic [2:0]  clock_input_sync;
		logic [2:0]  xtal_sync;
		logic        ref_tick;
	} cfg_t;

	cfg_t st;
	cfg_t next_st;

	logic vco_edge;
	logic clock_input_edge;
	logic xtal_edge;
	logic out_hs_pulse;
	logic out_ls_pulse;
	logic fb_hs_pulse;
	logic fb_ls_pulse;
	logic in_pulse;
	logic fr_pulse;

	// ----------------------------------------------------------------
	// ratio arithmetic
	// ----------------------------------------------------------------
	function automatic logic [3:0] hs_ratio(input logic [2:0] code);
		return {1'b0, code} + HS_RATIO_OFFSET;
	endfunction

	function automatic logic [20:0] ls_ratio(input logic [19:0] value);
		return {1'b0, value} + 21'h000001;
	endfunction

	function automatic logic [19:0] pre_ratio(input logic [18:0] value);
		return {1'b0, value} + 20'h00001;
	endfunction

	// edges taken from the second and third stages only
	assign vco_edge  = st.vco_sync[1] & ~st.vco_sync[2];
	assign clock_input_edge = st.clock_input_sync[1] & ~st.clock_input_sync[2];
	assign xtal_edge = st.xtal_sync[1] & ~st.xtal_sync[2];

	// ----------------------------------------------------------------
	// register file and next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.vco_sync  = {st.vco_sync[1:0], vco_pin};
		next_st.clock_input_sync = {st.clock_input_sync[1:0], clock_input};
		next_st.xtal_sync = {st.xtal_sync[1:0], crystal_reference_pins};
		next_st.ref_tick  = freerun_mode ? fr_pulse : in_pulse;  // [R8]
		// reads see the value before a write in the same cycle
		if (reg_read)
		begin
			case (reg_addr)
				OUT_HS_CTRL_ADDR:  next_st.rdata = st.out_hs_ctrl;
				OUT_LS_LOW_ADDR:   next_st.rdata = st.out_ls_low;
				FB_HIGH_CTRL_ADDR: next_st.rdata = st.fb_high_ctrl;
				FB_MID_ADDR:       next_st.rdata = st.fb_mid;
				FB_LOW_ADDR:       next_st.rdata = st.fb_low;
				IN_TOP_ADDR:       next_st.rdata = st.in_top;
				IN_MID_ADDR:       next_st.rdata = st.in_mid;
				IN_LOW_ADDR:       next_st.rdata = st.in_low;
				FR_TOP_ADDR:       next_st.rdata = st.fr_top;
				FR_MID_ADDR:       next_st.rdata = st.fr_mid;
				FR_LOW_ADDR:       next_st.rdata = st.fr_low;
				default:           next_st.rdata = UNMAPPED_READ;
			endcase
		end
		// reserved bits are dropped so they always read zero
		if (reg_write)
		begin
			case (reg_addr)
				OUT_HS_CTRL_ADDR:  next_st.out_hs_ctrl  = reg_wdata & HS_CTRL_MASK;  // [R9]
				OUT_LS_LOW_ADDR:   next_st.out_ls_low   = reg_wdata;  // [R2]
				FB_HIGH_CTRL_ADDR: next_st.fb_high_ctrl = reg_wdata & FB_HIGH_MASK;  // [R3]
				FB_MID_ADDR:       next_st.fb_mid       = reg_wdata;  // [R4]
				FB_LOW_ADDR:       next_st.fb_low       = reg_wdata;  // [R4]
				IN_TOP_ADDR:       next_st.in_top       = reg_wdata & TOP_BITS_MASK;  // [R7]
				IN_MID_ADDR:       next_st.in_mid       = reg_wdata;
				IN_LOW_ADDR:       next_st.in_low       = reg_wdata;
				FR_TOP_ADDR:       next_st.fr_top       = reg_wdata & TOP_BITS_MASK;  // [R8]
				FR_MID_ADDR:       next_st.fr_mid       = reg_wdata;
				FR_LOW_ADDR:       next_st.fr_low       = reg_wdata;
				default:           ;
			endcase
		end
		if (!reset_n)
		begin
			next_st = '0;
			next_st.out_hs_ctrl  = OUT_HS_CTRL_RST;
			next_st.out_ls_low   = OUT_LS_LOW_RST;  // [R2]
			next_st.fb_high_ctrl = FB_HIGH_CTRL_RST;  // [R6]
			next_st.fb_mid       = FB_MID_RST;  // [R6]
			next_st.fb_low       = FB_LOW_RST;  // [R6]
			next_st.in_top       = IN_TOP_RST;
			next_st.in_mid       = IN_MID_RST;
			next_st.in_low       = IN_LOW_RST;
			next_st.fr_top       = FR_TOP_RST;
			next_st.fr_mid       = FR_MID_RST;
			next_st.fr_low       = FR_LOW_RST;
		end
		// ratios follow the registers with no extra delay
		next_st.out_hs_ratio = hs_ratio(next_st.out_hs_ctrl[HS_CODE_LSB +: HS_CODE_W]);  // [R9]
		next_st.out_ls_ratio = ls_ratio({output_lowspeed_upper, next_st.out_ls_low});  // [R2]
		next_st.fb_hs_ratio  = hs_ratio(next_st.fb_high_ctrl[HS_CODE_LSB +: HS_CODE_W]);  // [R3]
		next_st.fb_ls_ratio  = ls_ratio({next_st.fb_high_ctrl[3:0], next_st.fb_mid,
			next_st.fb_low});  // [R4]
		next_st.in_ratio     = pre_ratio({next_st.in_top[2:0], next_st.in_mid,
			next_st.in_low});  // [R7]
		next_st.fr_ratio     = pre_ratio({next_st.fr_top[2:0], next_st.fr_mid,
			next_st.fr_low});  // [R8]
	end

	always_ff @(posedge clk)
		st <= next_st;

	// ----------------------------------------------------------------
	// divider chains
	// ----------------------------------------------------------------
	divider_stage #(.W(DIV_W)) u_out_hs (.clk(clk), .reset_n(reset_n), .tick(vco_edge),
		.ratio({17'h00000, st.out_hs_ratio}), .pulse(out_hs_pulse));
	divider_stage #(.W(DIV_W)) u_out_ls (.clk(clk), .reset_n(reset_n), .tick(out_hs_pulse),
		.ratio(st.out_ls_ratio), .pulse(out_ls_pulse));
	divider_stage #(.W(DIV_W)) u_fb_hs (.clk(clk), .reset_n(reset_n), .tick(vco_edge),
		.ratio({17'h00000, st.fb_hs_ratio}), .pulse(fb_hs_pulse));
	divider_stage #(.W(DIV_W)) u_fb_ls (.clk(clk), .reset_n(reset_n), .tick(fb_hs_pulse),
		.ratio(st.fb_ls_ratio), .pulse(fb_ls_pulse));
	divider_stage #(.W(DIV_W)) u_in_pre (.clk(clk), .reset_n(reset_n), .tick(clock_input_edge),
		.ratio({1'b0, st.in_ratio}), .pulse(in_pulse));
	divider_stage #(.W(DIV_W)) u_fr_pre (.clk(clk), .reset_n(reset_n), .tick(xtal_edge),
		.ratio({1'b0, st.fr_ratio}), .pulse(fr_pulse));

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata                    = st.rdata;
	assign output_highspeed_divider     = st.out_hs_ratio;
	assign output_lowspeed_divider      = st.out_ls_ratio;
	assign feedback_highspeed_divider   = st.fb_hs_ratio;
	assign feedback_lowspeed_divider    = st.fb_ls_ratio;
	assign clock_input_predivider       = st.in_ratio;
	assign freerun_reference_predivider = st.fr_ratio;
	assign clock_output                 = out_ls_pulse;
	assign feedback_pd_tick             = fb_ls_pulse;
	assign reference_pd_tick            = st.ref_tick;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_out_ls_reset;
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> (st.out_ls_low == 8'h31);
	endproperty
	a_out_ls_reset: assert property (p_out_ls_reset)  // [R2]
		else $error("output low byte not 0x31 after reset");

	property p_fb_hs_ratio;
		@(posedge clk) disable iff (!reset_n)
		(reg_write && reg_addr == FB_HIGH_CTRL_ADDR) |=>
			(feedback_highspeed_divider == {1'b0, $past(reg_wdata[7:5])} + 4'h4);
	endproperty
	a_fb_hs_ratio: assert property (p_fb_hs_ratio)  // [R3]
		else $error("feedback high-speed ratio is not code plus four");

	property p_fb_ls_ratio;
		@(posedge clk) disable iff (!reset_n)
		(reg_write && reg_addr == FB_LOW_ADDR) |=>
			(feedback_lowspeed_divider == {1'b0, st.fb_high_ctrl[3:0], st.fb_mid,
			$past(reg_wdata)} + 21'h000001);
	endproperty
	a_fb_ls_ratio: assert property (p_fb_ls_ratio)  // [R4]
		else $error("feedback low-speed ratio is not field plus one");

	property p_fb_reset;
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> (st.fb_high_ctrl == 8'hC0 && st.fb_mid == 8'h00
			&& st.fb_low == 8'hF9 && feedback_lowspeed_divider == 21'h0000FA);
	endproperty
	a_fb_reset: assert property (p_fb_reset)  // [R6]
		else $error("feedback registers wrong after reset");

	property p_in_top;
		@(posedge clk) disable iff (!reset_n)
		(reg_write && reg_addr == IN_TOP_ADDR) |=>
			(clock_input_predivider == {1'b0, $past(reg_wdata[2:0]), st.in_mid, st.in_low}
			+ 20'h00001 && st.in_top[7:3] == 5'h00);
	endproperty
	a_in_top: assert property (p_in_top)  // [R7]
		else $error("clock input predivider top bits wrong");

	property p_fr_select;
		@(posedge clk) disable iff (!reset_n)
		(freerun_mode && fr_pulse) |=> reference_pd_tick;
	endproperty
	a_fr_select: assert property (p_fr_select)  // [R8]
		else $error("free-run reference pulse not passed to phase detector");

	property p_out_hs_ratio;
		@(posedge clk) disable iff (!reset_n)
		(reg_write && reg_addr == OUT_HS_CTRL_ADDR) |=>
			(output_highspeed_divider == {1'b0, $past(reg_wdata[7:5])} + 4'h4);
	endproperty
	a_out_hs_ratio: assert property (p_out_hs_ratio)  // [R9]
		else $error("output high-speed ratio is not code plus four");

endmodule
`default_nettype wire

// >>> inc/pll_divider_pkg.sv
// constants shared by the divider configuration block and its divider stages
`default_nettype none
package pll_divider_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OUT_HS_CTRL_ADDR   = 8'h19;
	localparam logic [7:0] OUT_LS_LOW_ADDR    = 8'h21;
	localparam logic [7:0] FB_HIGH_CTRL_ADDR  = 8'h28;
	localparam logic [7:0] FB_MID_ADDR        = 8'h29;
	localparam logic [7:0] FB_LOW_ADDR        = 8'h2A;
	localparam logic [7:0] IN_TOP_ADDR        = 8'h2B;
	localparam logic [7:0] IN_MID_ADDR        = 8'h2C;
	localparam logic [7:0] IN_LOW_ADDR        = 8'h2D;
	localparam logic [7:0] FR_TOP_ADDR        = 8'h2E;
	localparam logic [7:0] FR_MID_ADDR        = 8'h2F;
	localparam logic [7:0] FR_LOW_ADDR        = 8'h30;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] OUT_HS_CTRL_RST    = 8'h20;
	localparam logic [7:0] OUT_LS_LOW_RST     = 8'h31;
	localparam logic [7:0] FB_HIGH_CTRL_RST   = 8'hC0;
	localparam logic [7:0] FB_MID_RST         = 8'h00;
	localparam logic [7:0] FB_LOW_RST         = 8'hF9;
	localparam logic [7:0] IN_TOP_RST         = 8'h00;
	localparam logic [7:0] IN_MID_RST         = 8'h00;
	localparam logic [7:0] IN_LOW_RST         = 8'h09;
	localparam logic [7:0] FR_TOP_RST         = 8'h00;
	localparam logic [7:0] FR_MID_RST         = 8'h00;
	localparam logic [7:0] FR_LOW_RST         = 8'h00;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// ----------------------------------------------------------------
	// field layout: writable bits of each register
	// ----------------------------------------------------------------
	localparam logic [7:0] HS_CTRL_MASK       = 8'hE0;
	localparam logic [7:0] FB_HIGH_MASK       = 8'hEF;
	localparam logic [7:0] TOP_BITS_MASK      = 8'h07;
	localparam int         HS_CODE_LSB        = 5;
	localparam int         HS_CODE_W          = 3;
	localparam int         LS_W               = 20;
	localparam int         PREDIV_W           = 19;
	localparam int         DIV_W              = 21;
	localparam logic [3:0] HS_RATIO_OFFSET    = 4'h4;

endpackage
`default_nettype wire

// >>> verification/pll_divider_config_bench.sv
// self-checking bench for the divider chain configuration block
`timescale 1ns/1ns
`default_nettype none
module pll_divider_config_bench
	import pll_divider_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [11:0] output_lowspeed_upper = 12'h000;
	logic        freerun_mode = 1'b0;
	logic        vco_pin = 1'b0;
	logic        clock_input = 1'b0;
	logic        crystal_reference_pins = 1'b0;
	logic [7:0]  reg_rdata;
	logic [3:0]  out_hs;
	logic [20:0] out_ls;
	logic [3:0]  fb_hs;
	logic [20:0] fb_ls;
	logic [19:0] in_pd;
	logic [19:0] fr_pd;
	logic        clock_output;
	logic        feedback_pd_tick;
	logic        reference_pd_tick;
	int          bad_count = 0;
	int          n_compared = 0;
	int          n_out;
	int          n_fb;
	int          n_ref;
	logic [7:0]  shadow [0:255];

	// register table: offset, value after reset, writable bits
	localparam logic [7:0] ADDRS [0:10] = '{OUT_HS_CTRL_ADDR, OUT_LS_LOW_ADDR, FB_HIGH_CTRL_ADDR,
		FB_MID_ADDR, FB_LOW_ADDR, IN_TOP_ADDR, IN_MID_ADDR, IN_LOW_ADDR, FR_TOP_ADDR,
		FR_MID_ADDR, FR_LOW_ADDR};
	localparam logic [7:0] RSTV [0:10] = '{8'h20, 8'h31, 8'hC0, 8'h00, 8'hF9, 8'h00, 8'h00,
		8'h09, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MASKS [0:10] = '{8'hE0, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'h07, 8'hFF,
		8'hFF, 8'h07, 8'hFF, 8'hFF};

	always #5 clk = ~clk;

	pll_divider_config dut (
		.clk                          (clk),
		.reset_n                      (reset_n),
		.reg_addr                     (reg_addr),
		.reg_wdata                    (reg_wdata),
		.reg_write                    (reg_write),
		.reg_read                     (reg_read),
		.reg_rdata                    (reg_rdata),
		.output_lowspeed_upper        (output_lowspeed_upper),
		.freerun_mode                 (freerun_mode),
		.vco_pin                      (vco_pin),
		.clock_input                  (clock_input),
		.crystal_reference_pins       (crystal_reference_pins),
		.output_highspeed_divider     (out_hs),
		.output_lowspeed_divider      (out_ls),
		.feedback_highspeed_divider   (fb_hs),
		.feedback_lowspeed_divider    (fb_ls),
		.clock_input_predivider       (in_pd),
		.freerun_reference_predivider (fr_pd),
		.clock_output                 (clock_output),
		.feedback_pd_tick             (feedback_pd_tick),
		.reference_pd_tick            (reference_pd_tick)
	);

	// pulse counters, cleared with the block so each run starts level
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			n_out <= 0;
			n_fb <= 0;
			n_ref <= 0;
		end
		else
		begin
			n_out <= n_out + ((clock_output === 1'b1) ? 1 : 0);
			n_fb <= n_fb + ((feedback_pd_tick === 1'b1) ? 1 : 0);
			n_ref <= n_ref + ((reference_pd_tick === 1'b1) ? 1 : 0);
		end
	end

	// ----------------------------------------------------------------
	// expectation functions and tasks
	// ----------------------------------------------------------------
	function automatic logic [3:0] hs_ratio(input logic [7:0] ctrl);
		return {1'b0, ctrl[7:5]} + 4'h4;
	endfunction

	function automatic logic [20:0] ls_ratio(input logic [7:0] hi, input logic [7:0] mid,
		input logic [7:0] lo);
		return {1'b0, hi[3:0], mid, lo} + 21'h000001;
	endfunction

	function automatic logic [19:0] pd_ratio(input logic [7:0] hi, input logic [7:0] mid,
		input logic [7:0] lo);
		return {1'b0, hi[2:0], mid, lo} + 20'h00001;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk);
		reg_write = 1'b0;
	endtask

	// mapped write; the shadow keeps only the writable bits
	task automatic wr_idx(input int i, input logic [7:0] d);
		wr(ADDRS[i], d);
		shadow[ADDRS[i]] = d & MASKS[i];
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clk);
		reg_read = 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask

	task automatic check_all;
		logic [7:0] v;
		for (int i = 0; i < 11; i++)
		begin
			rd(ADDRS[i], v);
			check("register", v, shadow[ADDRS[i]]);
		end
		check("fb_hs", fb_hs, hs_ratio(shadow[FB_HIGH_CTRL_ADDR]));
		check("fb_ls", fb_ls, ls_ratio(shadow[FB_HIGH_CTRL_ADDR], shadow[FB_MID_ADDR],
			shadow[FB_LOW_ADDR]));
		check("out_hs", out_hs, hs_ratio(shadow[OUT_HS_CTRL_ADDR]));
		check("out_ls", out_ls, {1'b0, output_lowspeed_upper, shadow[OUT_LS_LOW_ADDR]} + 21'h1);
		check("in_pd", in_pd, pd_ratio(shadow[IN_TOP_ADDR], shadow[IN_MID_ADDR],
			shadow[IN_LOW_ADDR]));
		check("fr_pd", fr_pd, pd_ratio(shadow[FR_TOP_ADDR], shadow[FR_MID_ADDR],
			shadow[FR_LOW_ADDR]));
	endtask

	task automatic do_reset;
		@(negedge clk);
		reset_n = 1'b0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		for (int i = 0; i < 11; i++)
			shadow[ADDRS[i]] = RSTV[i];
	endtask

	// rising edges on all three pins, slow enough for the synchronisers
	task automatic pins(input int n);
		repeat (n)
		begin
			@(negedge clk);
			{vco_pin, clock_input, crystal_reference_pins} = 3'b111;
			repeat (2) @(negedge clk);
			{vco_pin, clock_input, crystal_reference_pins} = 3'b000;
			@(negedge clk);
		end
		repeat (10) @(negedge clk);
	endtask

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [7:0] d;
		int         i;
		void'($urandom(51276));
		do_reset;
		check_all;
		repeat (40)
		begin
			i = $urandom_range(10);
			d = 8'($urandom);
			if (ADDRS[i] == OUT_LS_LOW_ADDR) d[0] = 1'b1;
			if (ADDRS[i] == FB_LOW_ADDR) d[0] = 1'b1;
			wr_idx(i, d & MASKS[i]);
			output_lowspeed_upper = 12'($urandom);
			check_all;
		end
		// every high-speed code, feedback ratio at its 2^20 ceiling
		wr_idx(3, 8'hFF);
		wr_idx(4, 8'hFF);
		for (int c = 0; c < 8; c++)
		begin
			wr_idx(0, {c[2:0], 5'h00});
			wr_idx(2, {c[2:0], 5'h0F});
			check_all;
		end
		// reserved bits are dropped, unmapped space is inert
		foreach (MASKS[k])
			if (MASKS[k] != 8'hFF) wr_idx(k, 8'hFF);
		wr(8'h22, 8'h5A);
		rd(8'h22, d);
		check("unmapped", d, 8'h00);
		check_all;
		// divided pulses: both chains at ratio 8, clock input predivider 4
		do_reset;
		output_lowspeed_upper = 12'h000;
		wr_idx(0, 8'h00);
		wr_idx(1, 8'h01);
		wr_idx(2, 8'h00);
		wr_idx(4, 8'h01);
		wr_idx(7, 8'h03);
		pins(80);
		check("out pulses", n_out, 10);
		check("fb pulses", n_fb, 10);
		check("ref pulses", n_ref, 20);
		// free-run: crystal reference predivided by 5
		do_reset;
		freerun_mode = 1'b1;
		wr_idx(10, 8'h04);
		pins(80);
		check("freerun pulses", n_ref, 16);
		wrap_up;
	end

	initial
	begin
		// well past the longest scenario, still far below the cycle budget
		#500000;
		bad_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
